// ==== aliu_pkg.sv ====
// Shared constants and types of the arithmetic and logic instruction unit.
// Assumes an AXI4-Lite master with 32-bit data and a 12-bit byte address.
package aliu_pkg;

	// --------------------------------------------------------------
	// Register map (byte addresses)
	// --------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CMD = 12'h000;
	localparam logic [11:0] ADDR_IMM = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_SREG = 12'h00C;
	localparam logic [11:0] ADDR_RESULT = 12'h010;
	localparam logic [4:0] WIN_GPR = 5'h02;
	localparam logic [4:0] WIN_IO = 5'h04;

	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DST_LSB = 8;
	localparam int CMD_SRC_LSB = 16;
	localparam int CMD_GO_BIT = 31;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_IOERR_BIT = 2;
	localparam int STAT_SREG_LSB = 8;
	localparam int SREG_C = 0;
	localparam int SREG_Z = 1;
	localparam int SREG_N = 2;
	localparam int SREG_V = 3;
	localparam int SREG_S = 4;
	localparam int SREG_H = 5;
	localparam logic [7:0] SREG_RST = 8'h00;
	localparam logic [7:0] GPR_RST = 8'h00;
	localparam logic [7:0] IO_RST = 8'h00;
	localparam logic [7:0] IMM_RST = 8'h00;
	localparam logic [7:0] MASK_ARITH = 8'h3F;
	localparam logic [7:0] MASK_LOGIC = 8'h1E;
	localparam logic [7:0] MASK_COM = 8'h1F;
	localparam logic [7:0] MASK_WORD = 8'h1F;
	localparam logic [7:0] WORD_IMM_MASK = 8'h3F;
	localparam logic [5:0] IO_BIT_LIMIT = 6'h20;
	localparam logic [4:0] IO_FLAG_IDX = 5'h0E;
	localparam logic [7:0] IO_FLAG_W1C = 8'hC0;
	localparam int IO_FLAG_LSB = 6;

	// --------------------------------------------------------------
	// Operation codes
	// --------------------------------------------------------------
	localparam logic [4:0] OP_ADD = 5'h00;
	localparam logic [4:0] OP_ADD_CARRY = 5'h01;
	localparam logic [4:0] OP_WORD_ADD_IMM = 5'h02;
	localparam logic [4:0] OP_SUB = 5'h03;
	localparam logic [4:0] OP_SUB_IMM = 5'h04;
	localparam logic [4:0] OP_SUB_CARRY_REG = 5'h05;
	localparam logic [4:0] OP_SUB_CARRY_IMM = 5'h06;
	localparam logic [4:0] OP_WORD_SUB_IMM = 5'h07;
	localparam logic [4:0] OP_AND = 5'h08;
	localparam logic [4:0] OP_AND_IMM = 5'h09;
	localparam logic [4:0] OP_OR = 5'h0A;
	localparam logic [4:0] OP_OR_IMM = 5'h0B;
	localparam logic [4:0] OP_XOR_REG = 5'h0C;
	localparam logic [4:0] OP_ONES_COMPLEMENT = 5'h0D;
	localparam logic [4:0] OP_NEGATE = 5'h0E;
	localparam logic [4:0] OP_SET_MASK = 5'h0F;
	localparam logic [4:0] OP_CLEAR_MASK = 5'h10;
	localparam logic [4:0] OP_INCREMENT = 5'h11;
	localparam logic [4:0] OP_DECREMENT = 5'h12;
	localparam logic [4:0] OP_IO_BIT_SET = 5'h13;
	localparam logic [4:0] OP_IO_BIT_CLEAR = 5'h14;

	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {st_idle, st_exec, st_word_hi} aliu_state_t;

	typedef struct packed {
		logic [4:0] op;
		logic [4:0] dst;
		logic [4:0] src;
	} aliu_cmd_t;

	typedef struct packed {
		logic [7:0] res;
		logic [7:0] sreg_mask;
		logic [7:0] sreg_val;
	} aliu_alu_out_t;

endpackage

// ==== aliu_alu.sv ====
// Combinational 8-bit result and status flag generator.
// Assumes operands already selected; word operations are sequenced outside.
module aliu_alu (
	input wire logic [4:0] op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] sreg,
	output aliu_pkg::aliu_alu_out_t out
);

	// Carry, half carry and overflow as {c, h, v}
	function automatic logic [2:0] arith_flags(input logic [7:0] x, input logic [7:0] y,
		input logic [7:0] r, input logic sub);
		logic c;
		logic h;
		logic v;
		if (sub) begin
			c = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
			h = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
			v = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
		end else begin
			c = (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]);
			h = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
			v = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
		end
		return {c, h, v};
	endfunction

	logic [7:0] x;
	logic [7:0] y;
	logic cin;
	logic sub;
	logic arith;
	logic keep_z;
	logic [7:0] r;
	logic [2:0] chv;
	logic [7:0] val;

	always_comb begin
		x = a;
		y = b;
		cin = 1'b0;
		sub = 1'b0;
		arith = 1'b0;
		keep_z = 1'b0;
		r = 8'h00;
		out.sreg_mask = aliu_pkg::MASK_LOGIC;
		unique case (op)
			aliu_pkg::OP_ADD, aliu_pkg::OP_WORD_ADD_IMM: arith = 1'b1;
			aliu_pkg::OP_ADD_CARRY: begin
				arith = 1'b1;
				cin = sreg[aliu_pkg::SREG_C];
			end
			aliu_pkg::OP_SUB, aliu_pkg::OP_SUB_IMM, aliu_pkg::OP_WORD_SUB_IMM: begin
				arith = 1'b1;
				sub = 1'b1;
			end
			aliu_pkg::OP_SUB_CARRY_REG, aliu_pkg::OP_SUB_CARRY_IMM: begin
				arith = 1'b1;
				sub = 1'b1;
				cin = sreg[aliu_pkg::SREG_C];
				keep_z = 1'b1;
			end
			aliu_pkg::OP_NEGATE: begin
				arith = 1'b1;
				sub = 1'b1;
				x = 8'h00;
				y = a;
			end
			aliu_pkg::OP_INCREMENT: begin
				arith = 1'b1;
				y = 8'h01;
			end
			aliu_pkg::OP_DECREMENT: begin
				arith = 1'b1;
				sub = 1'b1;
				y = 8'h01;
			end
			aliu_pkg::OP_AND, aliu_pkg::OP_AND_IMM: r = a & b;
			aliu_pkg::OP_OR, aliu_pkg::OP_OR_IMM: r = a | b;
			aliu_pkg::OP_SET_MASK: r = a | b;
			aliu_pkg::OP_CLEAR_MASK: r = a & (8'hFF - b);
			aliu_pkg::OP_XOR_REG: r = a ^ b;
			aliu_pkg::OP_ONES_COMPLEMENT: begin
				r = 8'hFF - a;
				out.sreg_mask = aliu_pkg::MASK_COM;
			end
			default: r = 8'h00;
		endcase
		if (arith) begin
			r = sub ? 8'(x - y - {7'h00, cin}) : 8'(x + y + {7'h00, cin});
			out.sreg_mask = (op == aliu_pkg::OP_INCREMENT || op == aliu_pkg::OP_DECREMENT) ?
				aliu_pkg::MASK_LOGIC : aliu_pkg::MASK_ARITH;
		end
		chv = arith_flags(x, y, r, sub);
		val = 8'h00;
		val[aliu_pkg::SREG_C] = arith ? chv[2] : (op == aliu_pkg::OP_ONES_COMPLEMENT);
		val[aliu_pkg::SREG_H] = arith & chv[1];
		val[aliu_pkg::SREG_V] = arith & chv[0];
		val[aliu_pkg::SREG_N] = r[7];
		val[aliu_pkg::SREG_Z] = (r == 8'h00) & (~keep_z | sreg[aliu_pkg::SREG_Z]);
		val[aliu_pkg::SREG_S] = val[aliu_pkg::SREG_N] ^ val[aliu_pkg::SREG_V];
		out.res = r;
		out.sreg_val = val;
	end

endmodule

// ==== aliu_top.sv ====
// Arithmetic and logic instruction unit with AXI4-Lite register access.
// Assumes one 25 MHz clock, synchronous active-low reset, inputs synchronous.
module aliu_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] io_flag_event,
	output logic busy,
	output logic exec_done
);

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	function automatic logic addr_mapped(input logic [11:0] addr);
		return addr == aliu_pkg::ADDR_CMD || addr == aliu_pkg::ADDR_IMM ||
			addr == aliu_pkg::ADDR_STATUS || addr == aliu_pkg::ADDR_SREG ||
			addr == aliu_pkg::ADDR_RESULT || addr[11:7] == aliu_pkg::WIN_GPR ||
			addr[11:7] == aliu_pkg::WIN_IO;
	endfunction

	// Write-one-to-clear on flag bits, plain store elsewhere
	function automatic logic [7:0] io_merge(input logic [4:0] idx, input logic [7:0] old,
		input logic [7:0] wval);
		logic [7:0] w1c;
		w1c = (idx == aliu_pkg::IO_FLAG_IDX) ? aliu_pkg::IO_FLAG_W1C : 8'h00;
		return (old & w1c & ~wval) | (wval & ~w1c);
	endfunction

	function automatic logic op_is_imm(input logic [4:0] op);
		return op == aliu_pkg::OP_SUB_IMM || op == aliu_pkg::OP_SUB_CARRY_IMM ||
			op == aliu_pkg::OP_AND_IMM || op == aliu_pkg::OP_OR_IMM ||
			op == aliu_pkg::OP_SET_MASK || op == aliu_pkg::OP_CLEAR_MASK;
	endfunction

	// ----------------------------------------------------------
	// State
	// ----------------------------------------------------------
	aliu_pkg::aliu_state_t state_ff, nxt_state;
	aliu_pkg::aliu_cmd_t cmd_ff;
	aliu_pkg::aliu_alu_out_t alu_out;
	logic [7:0] gpr_ff [32];
	logic [7:0] io_ff [32];
	logic [7:0] imm_ff, sreg_ff;
	logic [15:0] result_ff;
	logic err_ff, ioerr_ff, lo_carry_ff, lo_zero_ff, done_ff;
	logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [11:0] aw_addr_ff;
	logic [31:0] w_data_ff, rdata_ff;
	logic [3:0] w_strb_ff;
	logic [1:0] bresp_ff, rresp_ff;

	logic do_write, wr_cmd, wr_gpr, wr_io, go, go_refused;
	logic is_word, is_word_add, is_io, ex_gpr_we, ex_io_we, ex_io_bad, ex_done;
	logic [4:0] hi_idx, io_idx, alu_op, ex_gpr_idx;
	logic [7:0] alu_a, alu_b, alu_sreg, ex_sreg_mask, ex_sreg_val, ex_io_val;
	logic [7:0] flag_keep;

	// ----------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------
	assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign wr_cmd = do_write & (aw_addr_ff == aliu_pkg::ADDR_CMD);
	assign wr_gpr = do_write & (aw_addr_ff[11:7] == aliu_pkg::WIN_GPR) & w_strb_ff[0];
	assign wr_io = do_write & (aw_addr_ff[11:7] == aliu_pkg::WIN_IO) & w_strb_ff[0];
	assign go = wr_cmd & w_strb_ff[3] & w_data_ff[aliu_pkg::CMD_GO_BIT];
	assign go_refused = go & (state_ff != aliu_pkg::st_idle);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_ff <= 1'b1;
			aw_addr_ff <= {s_axi_awaddr[11:2], 2'b00};
		end else if (do_write) begin
			aw_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'b00;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= addr_mapped(aw_addr_ff) ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= 2'b00;
			rdata_ff <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			rdata_ff <= 32'h0000_0000;
			if (s_axi_araddr[11:7] == aliu_pkg::WIN_GPR)
				rdata_ff[7:0] <= gpr_ff[s_axi_araddr[6:2]];
			else if (s_axi_araddr[11:7] == aliu_pkg::WIN_IO)
				rdata_ff[7:0] <= io_ff[s_axi_araddr[6:2]];
			else if (s_axi_araddr[11:2] == aliu_pkg::ADDR_CMD[11:2]) begin
				rdata_ff[aliu_pkg::CMD_OP_LSB +: 5] <= cmd_ff.op;
				rdata_ff[aliu_pkg::CMD_DST_LSB +: 5] <= cmd_ff.dst;
				rdata_ff[aliu_pkg::CMD_SRC_LSB +: 5] <= cmd_ff.src;
			end else if (s_axi_araddr[11:2] == aliu_pkg::ADDR_IMM[11:2])
				rdata_ff[7:0] <= imm_ff;
			else if (s_axi_araddr[11:2] == aliu_pkg::ADDR_STATUS[11:2]) begin
				rdata_ff[aliu_pkg::STAT_BUSY_BIT] <= state_ff != aliu_pkg::st_idle;
				rdata_ff[aliu_pkg::STAT_ERR_BIT] <= err_ff;
				rdata_ff[aliu_pkg::STAT_IOERR_BIT] <= ioerr_ff;
				rdata_ff[aliu_pkg::STAT_SREG_LSB +: 8] <= sreg_ff;
			end else if (s_axi_araddr[11:2] == aliu_pkg::ADDR_SREG[11:2])
				rdata_ff[7:0] <= sreg_ff;
			else if (s_axi_araddr[11:2] == aliu_pkg::ADDR_RESULT[11:2])
				rdata_ff[15:0] <= result_ff;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Command and immediate
	// ----------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ff <= '0;
			imm_ff <= aliu_pkg::IMM_RST;
		end else if (state_ff == aliu_pkg::st_idle) begin
			if (wr_cmd && w_strb_ff[0])
				cmd_ff.op <= w_data_ff[aliu_pkg::CMD_OP_LSB +: 5];
			if (wr_cmd && w_strb_ff[1])
				cmd_ff.dst <= w_data_ff[aliu_pkg::CMD_DST_LSB +: 5];
			if (wr_cmd && w_strb_ff[2])
				cmd_ff.src <= w_data_ff[aliu_pkg::CMD_SRC_LSB +: 5];
			if (do_write && aw_addr_ff == aliu_pkg::ADDR_IMM && w_strb_ff[0])
				imm_ff <= w_data_ff[7:0];
		end
	end

	// ----------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------
	assign is_word_add = cmd_ff.op == aliu_pkg::OP_WORD_ADD_IMM;
	assign is_word = is_word_add || cmd_ff.op == aliu_pkg::OP_WORD_SUB_IMM;
	assign is_io = cmd_ff.op == aliu_pkg::OP_IO_BIT_SET || cmd_ff.op == aliu_pkg::OP_IO_BIT_CLEAR;
	assign hi_idx = 5'(cmd_ff.dst + 5'h01);
	assign io_idx = imm_ff[4:0];

	always_comb begin
		alu_op = cmd_ff.op;
		alu_a = gpr_ff[cmd_ff.dst];
		alu_b = op_is_imm(cmd_ff.op) ? imm_ff : gpr_ff[cmd_ff.src];
		alu_sreg = sreg_ff;
		if (state_ff == aliu_pkg::st_exec && is_word)
			alu_b = imm_ff & aliu_pkg::WORD_IMM_MASK;
		if (state_ff == aliu_pkg::st_word_hi) begin
			// High byte ripples the low byte's carry and zero
			alu_op = is_word_add ? aliu_pkg::OP_ADD_CARRY : aliu_pkg::OP_SUB_CARRY_REG;
			alu_a = gpr_ff[hi_idx];
			alu_b = 8'h00;
			alu_sreg[aliu_pkg::SREG_C] = lo_carry_ff;
			alu_sreg[aliu_pkg::SREG_Z] = lo_zero_ff;
		end
	end

	aliu_alu i_aliu_alu (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.sreg(alu_sreg),
		.out(alu_out)
	);

	always_comb begin
		nxt_state = state_ff;
		ex_gpr_we = 1'b0;
		ex_gpr_idx = cmd_ff.dst;
		ex_sreg_mask = 8'h00;
		ex_sreg_val = alu_out.sreg_val;
		ex_io_we = 1'b0;
		ex_io_val = io_ff[io_idx];
		ex_io_bad = 1'b0;
		ex_done = 1'b0;
		unique case (state_ff)
			aliu_pkg::st_idle: begin
				if (go)
					nxt_state = aliu_pkg::st_exec;
			end
			aliu_pkg::st_exec: begin
				if (is_word) begin
					ex_gpr_we = 1'b1;
					nxt_state = aliu_pkg::st_word_hi;
				end else if (is_io) begin
					if (imm_ff[5:0] >= aliu_pkg::IO_BIT_LIMIT)
						ex_io_bad = 1'b1;
					else
						ex_io_we = 1'b1;
					ex_io_val[cmd_ff.src[2:0]] = cmd_ff.op == aliu_pkg::OP_IO_BIT_SET;
					ex_done = 1'b1;
					nxt_state = aliu_pkg::st_idle;
				end else begin
					ex_gpr_we = 1'b1;
					ex_sreg_mask = alu_out.sreg_mask;
					ex_done = 1'b1;
					nxt_state = aliu_pkg::st_idle;
				end
			end
			aliu_pkg::st_word_hi: begin
				ex_gpr_we = 1'b1;
				ex_gpr_idx = hi_idx;
				ex_sreg_mask = aliu_pkg::MASK_WORD;
				ex_sreg_val[aliu_pkg::SREG_Z] = alu_out.sreg_val[aliu_pkg::SREG_Z] & lo_zero_ff;
				ex_done = 1'b1;
				nxt_state = aliu_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_ff <= aliu_pkg::st_idle;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_carry_ff <= 1'b0;
			lo_zero_ff <= 1'b0;
		end else if (state_ff == aliu_pkg::st_exec) begin
			lo_carry_ff <= alu_out.sreg_val[aliu_pkg::SREG_C];
			lo_zero_ff <= alu_out.sreg_val[aliu_pkg::SREG_Z];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_ff <= 16'h0000;
			done_ff <= 1'b0;
		end else begin
			done_ff <= ex_done;
			if (ex_gpr_we && state_ff == aliu_pkg::st_word_hi)
				result_ff[15:8] <= alu_out.res;
			else if (ex_gpr_we)
				result_ff <= {8'h00, alu_out.res};
		end
	end

	// ----------------------------------------------------------
	// Registers, status and I/O space
	// ----------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 32; i++)
				gpr_ff[i] <= aliu_pkg::GPR_RST;
		end else if (ex_gpr_we) begin
			gpr_ff[ex_gpr_idx] <= alu_out.res;
		end else if (wr_gpr) begin
			gpr_ff[aw_addr_ff[6:2]] <= w_data_ff[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sreg_ff <= aliu_pkg::SREG_RST;
		else if (ex_sreg_mask != 8'h00)
			sreg_ff <= (sreg_ff & ~ex_sreg_mask) | (ex_sreg_val & ex_sreg_mask);
		else if (do_write && aw_addr_ff == aliu_pkg::ADDR_SREG && w_strb_ff[0])
			sreg_ff <= w_data_ff[7:0];
	end

	// Hardware events win over a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_ff <= 1'b0;
			ioerr_ff <= 1'b0;
		end else begin
			if (go_refused)
				err_ff <= 1'b1;
			else if (do_write && aw_addr_ff == aliu_pkg::ADDR_STATUS && w_strb_ff[0] &&
				w_data_ff[aliu_pkg::STAT_ERR_BIT])
				err_ff <= 1'b0;
			if (ex_io_bad)
				ioerr_ff <= 1'b1;
			else if (do_write && aw_addr_ff == aliu_pkg::ADDR_STATUS && w_strb_ff[0] &&
				w_data_ff[aliu_pkg::STAT_IOERR_BIT])
				ioerr_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 32; i++)
				io_ff[i] <= aliu_pkg::IO_RST;
		end else begin
			if (ex_io_we)
				io_ff[io_idx] <= io_merge(io_idx, io_ff[io_idx], ex_io_val);
			else if (wr_io)
				io_ff[aw_addr_ff[6:2]] <= io_merge(aw_addr_ff[6:2], io_ff[aw_addr_ff[6:2]],
					w_data_ff[7:0]);
			if (io_flag_event != 2'b00)
				io_ff[aliu_pkg::IO_FLAG_IDX][aliu_pkg::IO_FLAG_LSB +: 2] <=
					flag_keep[aliu_pkg::IO_FLAG_LSB +: 2] | io_flag_event;
		end
	end

	// Flag bits after any same-cycle write-one clear
	assign flag_keep = io_merge(aliu_pkg::IO_FLAG_IDX, io_ff[aliu_pkg::IO_FLAG_IDX],
		(ex_io_we && io_idx == aliu_pkg::IO_FLAG_IDX) ? ex_io_val :
		(wr_io && !ex_io_we && aw_addr_ff[6:2] == aliu_pkg::IO_FLAG_IDX) ? w_data_ff[7:0] :
		8'h00);

	assign busy = state_ff != aliu_pkg::st_idle;
	assign exec_done = done_ff;

endmodule

// ==== aliu_checker.sv ====
// Concurrent checks on bus handshakes and execution timing of the unit.
// Assumes binding to aliu_top; every signal belongs to the aclk domain.
module aliu_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_wvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic busy,
	input wire logic exec_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_busy_bounded: assert property ($rose(busy) |-> ##[1:2] !busy)
		else $error("busy outlasted two cycles");
	a_done_follows: assert property ($fell(busy) && $past(aresetn) |-> exec_done)
		else $error("no done pulse after execution");
	a_done_single: assert property (exec_done |=> !exec_done)
		else $error("done pulse longer than one cycle");
	a_done_cause: assert property ($rose(exec_done) |-> $past(busy))
		else $error("done pulse without execution");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while stalled");
	a_write_blocked: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
		else $error("write accepted during response");
endmodule

// ==== aliu_flag_src.sv ====
// Peripheral stand-in raising the two clear-by-one status flag events.
// Assumes the bench requests events through fire; single aclk domain.
module aliu_flag_src (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] fire,
	output logic [1:0] io_flag_event
);
	timeunit 1ns;
	timeprecision 1ns;
	// One event cycle per request, quiet in reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_flag_event <= 2'h0;
		end else begin
			io_flag_event <= fire;
		end
	end
endmodule

// ==== tb_arith_logic_instruction_unit.sv ====
// Self-checking bench: bus tasks, operation table, flag and window cases.
// Assumes aliu_pkg, aliu_top, aliu_flag_src and aliu_checker compiled first.
module tb_arith_logic_instruction_unit;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [4:0] op;
		logic [15:0] a;
		logic [7:0] b;
		logic [7:0] sin;
		logic [15:0] res;
		logic [7:0] sout;
	} aliu_case_t;
	logic aclk, aresetn, awvalid, wvalid, bready, awready, wready, bvalid;
	logic arvalid, rready, arready, rvalid, busy, exec_done;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, val;
	logic [1:0] bresp, rresp, resp, fire, flag_ev;
	int n_mismatch, checks_done, n_done, n_busy, cyc;
	// Low byte register 24, neighbour 25 must stay untouched by byte ops
	aliu_case_t tbl [19] = '{
		'{5'h00, 16'h5A0F, 8'h01, 8'h00, 16'h5A10, 8'h20},
		'{5'h01, 16'h5AFF, 8'h00, 8'h01, 16'h5A00, 8'h23},
		'{5'h02, 16'h7FFF, 8'h01, 8'h00, 16'h8000, 8'h0C},
		'{5'h03, 16'h5A80, 8'h01, 8'h00, 16'h5A7F, 8'h38},
		'{5'h04, 16'h5A05, 8'h05, 8'h00, 16'h5A00, 8'h02},
		'{5'h05, 16'h5A00, 8'h00, 8'h03, 16'h5AFF, 8'h35},
		'{5'h06, 16'h5A10, 8'h10, 8'h02, 16'h5A00, 8'h02},
		'{5'h07, 16'h0000, 8'h01, 8'h00, 16'hFFFF, 8'h15},
		'{5'h08, 16'h5AF0, 8'h80, 8'h09, 16'h5A80, 8'h15},
		'{5'h09, 16'h5A0F, 8'hF0, 8'h20, 16'h5A00, 8'h22},
		'{5'h0A, 16'h5A01, 8'h02, 8'h00, 16'h5A03, 8'h00},
		'{5'h0B, 16'h5A80, 8'h01, 8'h00, 16'h5A81, 8'h14},
		'{5'h0C, 16'h5AAA, 8'hAA, 8'h00, 16'h5A00, 8'h02},
		'{5'h0D, 16'h5A0F, 8'h00, 8'h00, 16'h5AF0, 8'h15},
		'{5'h0E, 16'h5A01, 8'h00, 8'h00, 16'h5AFF, 8'h35},
		'{5'h0F, 16'h5A00, 8'h80, 8'h00, 16'h5A80, 8'h14},
		'{5'h10, 16'h5AFF, 8'h0F, 8'h00, 16'h5AF0, 8'h14},
		'{5'h11, 16'h5A7F, 8'h00, 8'h01, 16'h5A80, 8'h0D},
		'{5'h12, 16'h5A00, 8'h00, 8'h20, 16'h5AFF, 8'h34}};

	aliu_top i_aliu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_flag_event(flag_ev),
		.busy(busy), .exec_done(exec_done));
	aliu_flag_src i_aliu_flag_src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
		.io_flag_event(flag_ev));

	initial begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (exec_done === 1'h1) n_done++;
		if (busy === 1'h1) n_busy++;
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Bus master and operation helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		resp = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		val = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask
	task automatic go(input logic [4:0] op, input logic [4:0] dst, input logic [4:0] src);
		int n0;
		n0 = n_done;
		wr(aliu_pkg::ADDR_CMD, {1'h1, 10'h0, src, 3'h0, dst, 3'h0, op});
		for (int i = 0; i < 8 && n_done == n0; i++) @(posedge aclk);
	endtask
	task automatic run_case(input aliu_case_t c);
		int n0, b0;
		logic word;
		n0 = n_done;
		b0 = n_busy;
		word = c.op inside {aliu_pkg::OP_WORD_ADD_IMM, aliu_pkg::OP_WORD_SUB_IMM};
		wr(12'h160, {24'h0, c.a[7:0]});
		wr(12'h164, {24'h0, c.a[15:8]});
		wr(12'h108, {24'h0, c.b});
		wr(aliu_pkg::ADDR_IMM, {24'h0, c.b});
		wr(aliu_pkg::ADDR_SREG, {24'h0, c.sin});
		go(c.op, 5'h18, 5'h02);
		check(n_done - n0, 1);
		check(n_busy - b0, word ? 2 : 1);
		rd(12'h160);
		check(val, {24'h0, c.res[7:0]});
		rd(12'h164);
		check(val, {24'h0, c.res[15:8]});
		rd(aliu_pkg::ADDR_SREG);
		check(val, {24'h0, c.sout});
		rd(aliu_pkg::ADDR_RESULT);
		check(val, {16'h0, word ? c.res : {8'h0, c.res[7:0]}});
	endtask
	task automatic pulse_flags(input logic [1:0] f);
		fire <= f;
		@(posedge aclk);
		fire <= 2'h0;
		@(posedge aclk);
	endtask
	task automatic io_case;
		pulse_flags(2'h3);
		rd(12'h238);
		check(val, 32'h000000C0);
		wr(aliu_pkg::ADDR_IMM, 32'h0000000E);
		go(aliu_pkg::OP_IO_BIT_SET, 5'h00, 5'h00);
		rd(12'h238);
		check(val, 32'h00000001);
		pulse_flags(2'h2);
		wr(12'h238, 32'h00000081);
		rd(12'h238);
		check(val, 32'h00000001);
		pulse_flags(2'h3);
		go(aliu_pkg::OP_IO_BIT_CLEAR, 5'h00, 5'h00);
		rd(12'h238);
		check(val, 32'h00000000);
		wr(aliu_pkg::ADDR_IMM, 32'h0000001F);
		go(aliu_pkg::OP_IO_BIT_SET, 5'h00, 5'h07);
		rd(12'h27C);
		check(val, 32'h00000080);
		wr(aliu_pkg::ADDR_IMM, 32'h00000020);
		go(aliu_pkg::OP_IO_BIT_SET, 5'h00, 5'h07);
		rd(aliu_pkg::ADDR_STATUS);
		check({31'h0, val[2]}, 32'h1);
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
		{awaddr, araddr, wdata, fire} <= 58'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(aliu_pkg::ADDR_SREG);
		check(val, 32'h0);
		foreach (tbl[k]) run_case(tbl[k]);
		io_case;
		wr(12'h300, 32'h0);
		check({30'h0, resp}, 32'h2);
		rd(12'h300);
		check(val, 32'h0);
		check({30'h0, resp}, 32'h2);
		wrap_up;
	end
endmodule

bind aliu_top aliu_checker i_aliu_checker (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_wready(s_axi_wready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.busy(busy), .exec_done(exec_done));
